// ---- core/mlbd_regs.svh ----
// Constants for the muxed local bus DMA handshake block.
// Included by design files by bare name; definitions only.
`ifndef MLBD_REGS_SVH
`define MLBD_REGS_SVH
`define MLBD_BURST_MAX  4
`define MLBD_FIFO_DEPTH 16
`define MLBD_DATA_W     32
`define MLBD_LANES      4
`define MLBD_LA_W       27
`define MLBD_LA_LSB     2
`define MLBD_WORD_W     30
`endif

// ---- core/mlbd_pkg.sv ----
// Types shared by the muxed local bus DMA handshake block.
// Assumes nothing beyond a SystemVerilog compiler.
package mlbd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} mlbd_state_t;
endpackage : mlbd_pkg

// ---- core/mlbd_lane_par.sv ----
// Even parity per byte lane of a data word.
// Purely combinational; caller registers the result.
`timescale 1ns/100ps
module mlbd_lane_par #(
  parameter int LANES = 4
) (
  input  wire logic [8*LANES-1:0] data_in,
  output wire logic [LANES-1:0]   par_out
);
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // Bit set when lane holds odd ones, so lane plus bit is even
      assign par_out[g] = ^data_in[8*g +: 8];
    end
  endgenerate
endmodule : mlbd_lane_par

// ---- core/mlbd_fifo.sv ----
// First-word-fall-through FIFO for host writes headed to the local bus.
// Single clock; ready and valid are registered.
`timescale 1ns/100ps
module mlbd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             mclk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [CW-1:0]         count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_ready_in && out_valid_out;
  assign out_data_out = mem_r[rp_r];
  assign cnt_nxt      = CW'(count_out + CW'(push) - CW'(pop));

  always_ff @(posedge mclk_in)
  begin
    if (push)
      mem_r[wp_r] <= in_data_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      wp_r          <= '0;
      rp_r          <= '0;
      count_out     <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : AW'(wp_r + 1'b1);
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : AW'(rp_r + 1'b1);
      count_out     <= cnt_nxt;
      in_ready_out  <= cnt_nxt != CW'(DEPTH);
      out_valid_out <= cnt_nxt != '0;
    end
  end
endmodule : mlbd_fifo

// ---- core/mlbd_core.sv ----
// Local bus master side of a muxed address/data bus with demand DMA.
// Assumes bus ownership is already granted and zero wait state data beats.
//
// Operation
// - In demand mode, drive channel acknowledge low during each access of its transfer.
// - Active-low request inputs gate each demand-mode channel's transfers.
// - Drive transceiver enable low plus a direction output for local data buffers.
// - Direction low while receiving data, high while driving data out.
// - In status mode the shared pin shows write FIFO almost full by threshold.
// - In end-of-transfer mode, shared pin assertion terminates the active transfer.
// - Even parity, one bit per byte lane, four lanes.
// - Check parity on received data, generate parity on driven data.
// - Separate address bus carries physical address bits 28 down to 2.
// - Separate address increments each successive data beat of a burst.
// - Address phase on the muxed bus carries upper 30 address bits.
// - Data phase carries a full 32-bit word.
// - Address strobe low for exactly the first clock of an access.
// - Burst final low during the last data beat of an access.
// - Address latch enable high in address phase only.
`timescale 1ns/100ps
`include "mlbd_regs.svh"
module mlbd_core #(
  parameter int BURST_MAX  = `MLBD_BURST_MAX,
  parameter int FIFO_DEPTH = `MLBD_FIFO_DEPTH,
  parameter int CNT_W      = 16,
  parameter int FCW        = $clog2(FIFO_DEPTH) + 1
) (
  input  wire logic                  mclk_in,
  input  wire logic                  srst_in,
  input  wire logic [1:0]            cfg_ch_demand_in,
  input  wire logic                  cfg_shared_is_eot_in,
  input  wire logic [FCW-1:0]        cfg_af_level_in,
  input  wire logic                  dma_start_in,
  input  wire logic                  dma_start_ch_in,
  input  wire logic [31:0]           dma_start_addr_in,
  input  wire logic [CNT_W-1:0]      dma_start_words_in,
  input  wire logic                  dma_start_write_in,
  output logic [1:0]                 dma_armed_out,
  output logic                       dma_done_out,
  output logic                       dma_done_ch_out,
  output logic                       dma_done_eot_out,
  input  wire logic [31:0]           wr_data_in,
  input  wire logic                  wr_valid_in,
  output logic                       wr_ready_out,
  output logic [31:0]                rd_data_out,
  output logic                       rd_valid_out,
  output logic                       rd_par_err_out,
  input  wire logic                  dma_ch0_demand_req_n_in,
  input  wire logic                  dma_ch1_demand_req_n_in,
  output logic                       dma_ch0_demand_ack_n_out,
  output logic                       dma_ch1_demand_ack_n_out,
  output logic                       xcvr_enable_n_out,
  output logic                       xcvr_direction_out,
  input  wire logic                  dma_end_of_transfer_n_in,
  output logic                       host_wr_fifo_almost_full_out,
  output logic                       shared_pin_oe_out,
  input  wire logic [3:0]            lane_parity_in,
  output logic [3:0]                 lane_parity_out,
  output logic                       lane_parity_oe_out,
  output logic [`MLBD_LA_W-1:0]      local_addr_mid_out,
  output logic                       local_addr_mid_oe_out,
  input  wire logic [31:0]           local_addr_data_in,
  output logic [31:0]                local_addr_data_out,
  output logic                       local_addr_data_oe_out,
  output logic                       addr_strobe_n_out,
  output logic                       addr_strobe_n_oe_out,
  output logic                       burst_final_n_out,
  output logic                       burst_final_n_oe_out,
  output logic                       ale_out
);
  localparam int BLW = $clog2(BURST_MAX + 1);

  mlbd_pkg::mlbd_state_t st_r;
  logic [1:0]                 req_s1_r, req_s2_r;
  logic                       eot_s1_r, eot_s2_r;
  logic [31:0]                lad_s1_r, lad_s2_r;
  logic [3:0]                 par_s1_r, par_s2_r;
  logic [`MLBD_WORD_W-1:0]    addr_r [2];
  logic [CNT_W-1:0]           left_r [2];
  logic [1:0]                 wr_r;
  logic                       ch_r;
  logic [BLW-1:0]             blen_r;
  logic                       beat_rd_r;
  logic [1:0]                 rd_pipe_r;
  logic [31:0]                fifo_data;
  logic                       fifo_valid;
  logic                       fifo_pop;
  logic [FCW-1:0]             fifo_cnt;
  logic [3:0]                 par_gen, par_chk;
  logic [1:0]                 ch_ok;
  logic [BLW-1:0]             len_c [2];
  logic                       pick_ch;
  logic                       eot_act;
  logic                       req_act;
  logic                       launch;
  logic                       beat_last;
  logic                       terminate;

  // Two-stage capture of every pin input
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      req_s1_r <= 2'h3;
      req_s2_r <= 2'h3;
      eot_s1_r <= 1'b1;
      eot_s2_r <= 1'b1;
      lad_s1_r <= 32'h0;
      lad_s2_r <= 32'h0;
      par_s1_r <= 4'h0;
      par_s2_r <= 4'h0;
    end
    else
    begin
      req_s1_r <= {dma_ch1_demand_req_n_in, dma_ch0_demand_req_n_in};
      req_s2_r <= req_s1_r;
      eot_s1_r <= dma_end_of_transfer_n_in;
      eot_s2_r <= eot_s1_r;
      lad_s1_r <= local_addr_data_in;
      lad_s2_r <= lad_s1_r;
      par_s1_r <= lane_parity_in;
      par_s2_r <= par_s1_r;
    end
  end

  mlbd_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .CW    (FCW)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .in_data_in    (wr_data_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .count_out     (fifo_cnt)
  );

  mlbd_lane_par #(.LANES(`MLBD_LANES)) u_par_gen (
    .data_in (fifo_data),
    .par_out (par_gen)
  );

  mlbd_lane_par #(.LANES(`MLBD_LANES)) u_par_chk (
    .data_in (lad_s2_r),
    .par_out (par_chk)
  );

  // Channel eligibility; writes wait until the whole burst sits in the FIFO
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      len_c[i] = (left_r[i] < CNT_W'(BURST_MAX)) ? BLW'(left_r[i]) : BLW'(BURST_MAX);
      ch_ok[i] = dma_armed_out[i] && (!cfg_ch_demand_in[i] || !req_s2_r[i])
                 && (!wr_r[i] || fifo_cnt >= FCW'(len_c[i]));
    end
  end

  assign pick_ch   = !ch_ok[0];
  assign eot_act   = cfg_shared_is_eot_in && !eot_s2_r;
  assign req_act   = !cfg_ch_demand_in[ch_r] || !req_s2_r[ch_r];
  assign launch    = (st_r == mlbd_pkg::ST_ADDR)
                     || (st_r == mlbd_pkg::ST_DATA && burst_final_n_out);
  assign beat_last = blen_r == BLW'(1) || left_r[ch_r] == CNT_W'(1) || eot_act || !req_act;
  assign terminate = left_r[ch_r] == CNT_W'(1) || eot_act;
  assign fifo_pop  = launch && wr_r[ch_r];

  // Access sequencer
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      st_r   <= mlbd_pkg::ST_IDLE;
      ch_r   <= 1'b0;
      blen_r <= '0;
    end
    else
    begin
      unique case (st_r)
        mlbd_pkg::ST_IDLE:
          if (|ch_ok)
          begin
            st_r   <= mlbd_pkg::ST_ADDR;
            ch_r   <= pick_ch;
            blen_r <= len_c[pick_ch];
          end
        mlbd_pkg::ST_ADDR:
        begin
          st_r   <= mlbd_pkg::ST_DATA;
          blen_r <= BLW'(blen_r - 1'b1);
        end
        mlbd_pkg::ST_DATA:
          if (!burst_final_n_out)
            st_r <= mlbd_pkg::ST_IDLE;
          else
            blen_r <= BLW'(blen_r - 1'b1);
      endcase
    end
  end

  // Per-channel descriptors; a start on an armed channel is ignored
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      dma_armed_out    <= 2'h0;
      wr_r             <= 2'h0;
      addr_r[0]        <= '0;
      addr_r[1]        <= '0;
      left_r[0]        <= '0;
      left_r[1]        <= '0;
      dma_done_out     <= 1'b0;
      dma_done_ch_out  <= 1'b0;
      dma_done_eot_out <= 1'b0;
    end
    else
    begin
      dma_done_out <= 1'b0;
      if (launch)
      begin
        addr_r[ch_r] <= `MLBD_WORD_W'(addr_r[ch_r] + 1'b1);
        left_r[ch_r] <= CNT_W'(left_r[ch_r] - 1'b1);
        if (terminate)
        begin
          dma_armed_out[ch_r] <= 1'b0;
          dma_done_out        <= 1'b1;
          dma_done_ch_out     <= ch_r;
          dma_done_eot_out    <= eot_act;
        end
      end
      if (dma_start_in && !dma_armed_out[dma_start_ch_in] && dma_start_words_in != '0)
      begin
        dma_armed_out[dma_start_ch_in] <= 1'b1;
        wr_r[dma_start_ch_in]          <= dma_start_write_in;
        addr_r[dma_start_ch_in]        <= dma_start_addr_in[31:2];
        left_r[dma_start_ch_in]        <= dma_start_words_in;
      end
    end
  end

  // Bus pins, all registered
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      addr_strobe_n_out      <= 1'b1;
      addr_strobe_n_oe_out   <= 1'b0;
      burst_final_n_out      <= 1'b1;
      burst_final_n_oe_out   <= 1'b0;
      ale_out                <= 1'b0;
      local_addr_mid_out     <= '0;
      local_addr_mid_oe_out  <= 1'b0;
      local_addr_data_out    <= 32'h0;
      local_addr_data_oe_out <= 1'b0;
      lane_parity_out        <= 4'h0;
      lane_parity_oe_out     <= 1'b0;
      xcvr_enable_n_out      <= 1'b1;
      xcvr_direction_out     <= 1'b1;
      beat_rd_r              <= 1'b0;
    end
    else if (st_r == mlbd_pkg::ST_IDLE && |ch_ok)
    begin
      addr_strobe_n_out      <= 1'b0;
      ale_out                <= 1'b1;
      addr_strobe_n_oe_out   <= 1'b1;
      burst_final_n_oe_out   <= 1'b1;
      local_addr_mid_oe_out  <= 1'b1;
      local_addr_mid_out     <= addr_r[pick_ch][`MLBD_LA_W-1:0];
      local_addr_data_out    <= {addr_r[pick_ch], 2'b00};
      local_addr_data_oe_out <= 1'b1;
      lane_parity_out        <= 4'h0;
      lane_parity_oe_out     <= 1'b0;
      xcvr_enable_n_out      <= 1'b0;
      xcvr_direction_out     <= 1'b1;
    end
    else if (launch)
    begin
      addr_strobe_n_out      <= 1'b1;
      ale_out                <= 1'b0;
      burst_final_n_out      <= !beat_last;
      local_addr_mid_out     <= addr_r[ch_r][`MLBD_LA_W-1:0];
      local_addr_data_out    <= wr_r[ch_r] ? fifo_data : 32'h0;
      local_addr_data_oe_out <= wr_r[ch_r];
      lane_parity_out        <= wr_r[ch_r] ? par_gen : 4'h0;
      lane_parity_oe_out     <= wr_r[ch_r];
      xcvr_direction_out     <= wr_r[ch_r];
      beat_rd_r              <= !wr_r[ch_r];
    end
    else
    begin
      addr_strobe_n_out      <= 1'b1;
      addr_strobe_n_oe_out   <= 1'b0;
      burst_final_n_out      <= 1'b1;
      burst_final_n_oe_out   <= 1'b0;
      ale_out                <= 1'b0;
      local_addr_mid_oe_out  <= 1'b0;
      local_addr_data_oe_out <= 1'b0;
      lane_parity_oe_out     <= 1'b0;
      xcvr_enable_n_out      <= 1'b1;
      xcvr_direction_out     <= 1'b1;
      beat_rd_r              <= 1'b0;
    end
  end

  // Acknowledge tracks the owning channel from address phase to last beat
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      dma_ch0_demand_ack_n_out <= 1'b1;
      dma_ch1_demand_ack_n_out <= 1'b1;
    end
    else if (st_r == mlbd_pkg::ST_IDLE && |ch_ok)
    begin
      dma_ch0_demand_ack_n_out <= !(cfg_ch_demand_in[0] && !pick_ch);
      dma_ch1_demand_ack_n_out <= !(cfg_ch_demand_in[1] && pick_ch);
    end
    else if (st_r == mlbd_pkg::ST_DATA && !burst_final_n_out)
    begin
      dma_ch0_demand_ack_n_out <= 1'b1;
      dma_ch1_demand_ack_n_out <= 1'b1;
    end
  end

  // Read data lags the bus by the capture stages; checked after them
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      rd_pipe_r      <= 2'h0;
      rd_valid_out   <= 1'b0;
      rd_data_out    <= 32'h0;
      rd_par_err_out <= 1'b0;
    end
    else
    begin
      rd_pipe_r    <= {rd_pipe_r[0], beat_rd_r};
      rd_valid_out <= rd_pipe_r[1];
      if (rd_pipe_r[1])
      begin
        rd_data_out    <= lad_s2_r;
        rd_par_err_out <= par_chk != par_s2_r;
      end
    end
  end

  // Shared pin: driven only as status output
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      host_wr_fifo_almost_full_out <= 1'b0;
      shared_pin_oe_out            <= 1'b0;
    end
    else
    begin
      host_wr_fifo_almost_full_out <= !cfg_shared_is_eot_in
                                      && fifo_cnt >= cfg_af_level_in;
      shared_pin_oe_out            <= !cfg_shared_is_eot_in;
    end
  end

  a_ads_one_clock: assert property (@(posedge mclk_in) disable iff (srst_in)
    !addr_strobe_n_out |=> addr_strobe_n_out && !ale_out)
    else $error("address strobe held past first clock");
  a_ale_with_ads: assert property (@(posedge mclk_in) disable iff (srst_in)
    ale_out == !addr_strobe_n_out)
    else $error("latch enable outside address phase");
  a_burst_final_n_ends_access: assert property (@(posedge mclk_in) disable iff (srst_in)
    !burst_final_n_out && local_addr_mid_oe_out |=> burst_final_n_out)
    else $error("burst final held two beats");
  a_burst_bounded: assert property (@(posedge mclk_in) disable iff (srst_in)
    !addr_strobe_n_out |-> ##[1:4] !burst_final_n_out)
    else $error("access longer than burst limit");
  a_addr_incr: assert property (@(posedge mclk_in) disable iff (srst_in)
    addr_strobe_n_out && burst_final_n_oe_out && $past(burst_final_n_out)
      && $past(addr_strobe_n_out) && $past(burst_final_n_oe_out)
      |-> local_addr_mid_out == `MLBD_LA_W'($past(local_addr_mid_out) + 1'b1))
    else $error("address did not step by one word");
  a_addr_match: assert property (@(posedge mclk_in) disable iff (srst_in)
    !addr_strobe_n_out |-> local_addr_data_out[`MLBD_LA_W+1:2] == local_addr_mid_out)
    else $error("separate and muxed address differ");
  a_dir_receive: assert property (@(posedge mclk_in) disable iff (srst_in)
    !xcvr_enable_n_out |-> xcvr_direction_out == local_addr_data_oe_out)
    else $error("direction disagrees with data drive");
  a_par_even: assert property (@(posedge mclk_in) disable iff (srst_in)
    lane_parity_oe_out |-> (^{local_addr_data_out[7:0], lane_parity_out[0]}) == 1'b0
      && (^{local_addr_data_out[31:24], lane_parity_out[3]}) == 1'b0)
    else $error("driven lane parity not even");
  a_ack_demand: assert property (@(posedge mclk_in) disable iff (srst_in)
    !dma_ch0_demand_ack_n_out |-> cfg_ch_demand_in[0] && !xcvr_enable_n_out)
    else $error("acknowledge outside a demand transfer");
  a_af_status: assert property (@(posedge mclk_in) disable iff (srst_in)
    host_wr_fifo_almost_full_out |-> shared_pin_oe_out)
    else $error("almost full shown while pin is input");
  a_pop_has_data: assert property (@(posedge mclk_in) disable iff (srst_in)
    fifo_pop |-> fifo_valid)
    else $error("write beat launched from empty buffer");
endmodule : mlbd_core

// ---- testbench/mlbd_bus_model.sv ----
// Behavioural local bus slave memory standing on the far side of the bus.
// Assumes zero wait state beats and the same clock as the bus master.
`timescale 1ns/100ps
module mlbd_bus_model (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        ads_n_in,
  input  wire logic        final_n_in,
  input  wire logic [26:0] mid_in,
  input  wire logic [31:0] lad_in,
  input  wire logic        lad_oe_in,
  input  wire logic        dir_in,
  input  wire logic [3:0]  par_in,
  input  wire logic        bad_par_in,
  output logic [31:0]      lad_out,
  output logic [3:0]       par_out,
  output logic [7:0]       err_cnt_out
);
  logic [31:0] mem [64];
  logic [31:0] last_r;
  logic [3:0]  last_par_r;
  logic [26:0] ptr_r;
  logic        active_r;
  logic        drv;
  function automatic logic [3:0] even_par(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      even_par[i] = ^d[8*i+:8];
  endfunction : even_par
  initial
  begin
    last_r     = 32'h0;
    last_par_r = 4'h0;
    active_r   = 1'b0;
    for (int i = 0; i < 64; i++)
      mem[i] = 32'ha5c30000 + i;
  end
  // Released lines show inverted history so stale data never looks valid
  assign drv     = active_r && !lad_oe_in && !dir_in;
  assign lad_out = drv ? mem[ptr_r[5:0]] : ~last_r;
  assign par_out = drv ? (even_par(mem[ptr_r[5:0]]) ^ {3'h0, bad_par_in}) : ~last_par_r;
  always @(posedge mclk_in)
  begin
    last_r     <= lad_out;
    last_par_r <= par_out;
    if (srst_in)
    begin
      active_r    <= 1'b0;
      err_cnt_out <= 8'h00;
    end
    else if (!ads_n_in)
    begin
      ptr_r    <= mid_in;
      active_r <= 1'b1;
      if (lad_in[28:2] !== mid_in) err_cnt_out <= err_cnt_out + 8'h01;
    end
    else if (active_r)
    begin
      ptr_r <= ptr_r + 27'h1;
      if (mid_in !== ptr_r || (lad_oe_in && par_in !== even_par(lad_in)))
        err_cnt_out <= err_cnt_out + 8'h01;
      if (lad_oe_in) mem[ptr_r[5:0]] <= lad_in;
      if (!final_n_in) active_r <= 1'b0;
    end
  end
endmodule : mlbd_bus_model

// ---- testbench/tb_muxed_local_bus_dma_handshake.sv ----
// Self-checking bench for the muxed local bus DMA master.
// Assumes the bus model above as the only local bus slave.
`timescale 1ns/100ps
module tb_muxed_local_bus_dma_handshake;
  logic        mclk_in, srst_in, cfg_shared_is_eot_in, dma_start_in, dma_start_ch_in;
  logic        dma_start_write_in, wr_valid_in, dma_end_of_transfer_n_in, bad_par;
  logic        dma_ch0_demand_req_n_in, dma_ch1_demand_req_n_in;
  logic [1:0]  cfg_ch_demand_in, dma_armed_out, ack_seen;
  logic [4:0]  cfg_af_level_in;
  logic [31:0] dma_start_addr_in, wr_data_in, rd_data_out, local_addr_data_in;
  logic [31:0] local_addr_data_out;
  logic [15:0] dma_start_words_in;
  logic        dma_done_out, dma_done_ch_out, dma_done_eot_out, wr_ready_out, rd_valid_out;
  logic        rd_par_err_out, dma_ch0_demand_ack_n_out, dma_ch1_demand_ack_n_out;
  logic        xcvr_enable_n_out, xcvr_direction_out, host_wr_fifo_almost_full_out;
  logic        shared_pin_oe_out, lane_parity_oe_out, local_addr_mid_oe_out, ale_out;
  logic        local_addr_data_oe_out, addr_strobe_n_out, addr_strobe_n_oe_out;
  logic        burst_final_n_out, burst_final_n_oe_out, done_ch, done_eot;
  logic [3:0]  lane_parity_in, lane_parity_out;
  logic [26:0] local_addr_mid_out;
  logic [7:0]  model_err;
  int          error_cnt, compares, ads_cnt, beat_cnt, par_errs;
  logic [31:0] rdq [$];

  mlbd_core #(.BURST_MAX(4), .FIFO_DEPTH(16)) dut (
    .mclk_in, .srst_in, .cfg_ch_demand_in, .cfg_shared_is_eot_in, .cfg_af_level_in,
    .dma_start_in, .dma_start_ch_in, .dma_start_addr_in, .dma_start_words_in,
    .dma_start_write_in, .dma_armed_out, .dma_done_out, .dma_done_ch_out, .dma_done_eot_out,
    .wr_data_in, .wr_valid_in, .wr_ready_out, .rd_data_out, .rd_valid_out, .rd_par_err_out,
    .dma_ch0_demand_req_n_in, .dma_ch1_demand_req_n_in, .dma_ch0_demand_ack_n_out,
    .dma_ch1_demand_ack_n_out, .xcvr_enable_n_out, .xcvr_direction_out,
    .dma_end_of_transfer_n_in, .host_wr_fifo_almost_full_out, .shared_pin_oe_out,
    .lane_parity_in, .lane_parity_out, .lane_parity_oe_out, .local_addr_mid_out,
    .local_addr_mid_oe_out, .local_addr_data_in, .local_addr_data_out,
    .local_addr_data_oe_out, .addr_strobe_n_out, .addr_strobe_n_oe_out,
    .burst_final_n_out, .burst_final_n_oe_out, .ale_out);

  mlbd_bus_model model (
    .mclk_in, .srst_in, .ads_n_in(addr_strobe_n_out), .final_n_in(burst_final_n_out),
    .mid_in(local_addr_mid_out), .lad_in(local_addr_data_out),
    .lad_oe_in(local_addr_data_oe_out), .dir_in(xcvr_direction_out),
    .par_in(lane_parity_out), .bad_par_in(bad_par), .lad_out(local_addr_data_in),
    .par_out(lane_parity_in), .err_cnt_out(model_err));

  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  task automatic start_dma(input logic ch, input logic [31:0] a, input logic [15:0] w,
                           input logic wr);
    ads_cnt = 0;
    beat_cnt = 0;
    par_errs = 0;
    ack_seen = 2'b00;
    rdq.delete();
    dma_start_in       <= 1'b1;
    dma_start_ch_in    <= ch;
    dma_start_addr_in  <= a;
    dma_start_words_in <= w;
    dma_start_write_in <= wr;
    @(posedge mclk_in);
    dma_start_in <= 1'b0;
  endtask : start_dma

  task automatic wait_done();
    int n;
    n = 0;
    @(posedge mclk_in);
    while (dma_done_out !== 1'b1 && n < 3000)
    begin
      @(posedge mclk_in);
      n++;
    end
    chk(n < 3000, 1, "done pulse");
    done_ch  = dma_done_ch_out;
    done_eot = dma_done_eot_out;
    cyc(6);
  endtask : wait_done

  // Monitor of every bus cycle
  always @(posedge mclk_in)
    if (!srst_in)
    begin
      if (rd_valid_out) rdq.push_back(rd_data_out);
      if (rd_valid_out && rd_par_err_out) par_errs++;
      if (!addr_strobe_n_out) ads_cnt++;
      if (!dma_ch0_demand_ack_n_out) ack_seen[0] = 1'b1;
      if (!dma_ch1_demand_ack_n_out) ack_seen[1] = 1'b1;
      chk(ale_out, !addr_strobe_n_out, "latch enable");
      if (!xcvr_enable_n_out && addr_strobe_n_out)
      begin
        beat_cnt++;
        chk(xcvr_direction_out, local_addr_data_oe_out, "direction");
        chk({addr_strobe_n_oe_out, local_addr_mid_oe_out}, 2'h3, "beat drive");
        chk(burst_final_n_oe_out, 1, "final drive");
        chk(lane_parity_oe_out, local_addr_data_oe_out, "parity drive");
      end
    end

  task automatic t_write();
    cfg_ch_demand_in <= 2'b01;
    cfg_af_level_in  <= 5'h0c;
    cyc(2);
    chk(host_wr_fifo_almost_full_out, 0, "almost full empty");
    chk(shared_pin_oe_out, 1, "status pin drive");
    wr_valid_in <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      wr_data_in <= 32'h10000000 + i;
      @(posedge mclk_in);
      while (wr_ready_out !== 1'b1) @(posedge mclk_in);
    end
    wr_data_in <= 32'hdeadbeef;
    repeat (3)
    begin
      @(posedge mclk_in);
      chk(wr_ready_out, 0, "full refuses");
    end
    wr_valid_in <= 1'b0;
    chk(host_wr_fifo_almost_full_out, 1, "almost full");
    start_dma(1'b0, 32'h40, 16'h10, 1'b1);
    cyc(20);
    chk(ads_cnt, 0, "no request no access");
    chk(dma_armed_out, 2'b01, "armed");
    dma_ch0_demand_req_n_in <= 1'b0;
    wait_done();
    dma_ch0_demand_req_n_in <= 1'b1;
    chk({done_ch, done_eot}, 0, "done channel");
    chk(ads_cnt, 4, "burst count");
    chk(beat_cnt, 16, "beat count");
    chk(ack_seen, 2'b01, "demand ack");
    chk(dma_ch0_demand_ack_n_out, 1, "ack released");
    for (int i = 0; i < 16; i++)
      chk(model.mem[16+i], 32'h10000000 + i, "written word");
    chk(host_wr_fifo_almost_full_out, 0, "almost full drained");
    $display("test write finished");
  endtask : t_write

  task automatic t_read();
    cfg_ch_demand_in        <= 2'b10;
    dma_ch1_demand_req_n_in <= 1'b0;
    cyc(3);
    start_dma(1'b1, 32'h80, 16'h5, 1'b0);
    wait_done();
    dma_ch1_demand_req_n_in <= 1'b1;
    chk(done_ch, 1, "done channel");
    chk(ack_seen, 2'b10, "demand ack");
    chk(ads_cnt, 2, "burst count");
    chk(rdq.size(), 5, "read beats");
    for (int i = 0; i < 5; i++)
      chk(rdq[i], 32'ha5c30020 + i, "read word");
    chk(par_errs, 0, "clean parity");
    $display("test read finished");
  endtask : t_read

  task automatic t_par();
    cfg_ch_demand_in <= 2'b00;
    bad_par          <= 1'b1;
    start_dma(1'b0, 32'h100, 16'h0, 1'b0);
    cyc(2);
    chk(dma_armed_out, 2'b00, "zero words ignored");
    start_dma(1'b0, 32'h100, 16'h1, 1'b0);
    wait_done();
    bad_par <= 1'b0;
    chk(par_errs, 1, "parity error flagged");
    chk(rdq.size(), 1, "single beat");
    $display("test parity finished");
  endtask : t_par

  task automatic t_eot();
    cfg_shared_is_eot_in <= 1'b1;
    cyc(3);
    chk(shared_pin_oe_out, 0, "pin is input");
    start_dma(1'b0, 32'h0, 16'h28, 1'b0);
    cyc(10);
    dma_end_of_transfer_n_in <= 1'b0;
    wait_done();
    dma_end_of_transfer_n_in <= 1'b1;
    chk(done_eot, 1, "ended by eot");
    chk(dma_armed_out, 2'b00, "disarmed");
    chk(rdq.size() < 40, 1, "cut short");
    $display("test end of transfer finished");
  endtask : t_eot

  initial
  begin
    srst_in = 1'b1;
    cfg_ch_demand_in = 2'b00;
    cfg_shared_is_eot_in = 1'b0;
    cfg_af_level_in = 5'h0c;
    dma_start_in = 1'b0;
    dma_start_ch_in = 1'b0;
    dma_start_addr_in = 32'h0;
    dma_start_words_in = 16'h0;
    dma_start_write_in = 1'b0;
    wr_data_in = 32'h0;
    wr_valid_in = 1'b0;
    dma_ch0_demand_req_n_in = 1'b1;
    dma_ch1_demand_req_n_in = 1'b1;
    dma_end_of_transfer_n_in = 1'b1;
    bad_par = 1'b0;
    cyc(4);
    srst_in <= 1'b0;
    cyc(3);
    chk({xcvr_enable_n_out, addr_strobe_n_out, local_addr_data_oe_out}, 3'h6, "idle");
    chk(dma_ch0_demand_ack_n_out, 1, "ack idle");
    chk(wr_ready_out, 1, "ready after reset");
    t_write();
    t_read();
    t_par();
    t_eot();
    chk(model_err, 0, "bus model checks");
    final_report();
  end

  initial
  begin
    cyc(20000);
    chk(0, 1, "watchdog expired");
    final_report();
  end
endmodule : tb_muxed_local_bus_dma_handshake
